/* dv/pms_mdio_props.sv */
// Purpose: Port checker for the serial management slave
// Assumes: Sees only the top module ports
// Notes: Bound to every slave instance
`timescale 1ns/100ps
`include "pms_consts.vh"
module pms_mdio_props #(
  parameter DW = 16
) (
  // System
  input wire clk,
  input wire rst_b,
  // Management pins
  input wire mdc,
  input wire mdio_out_r,
  input wire mdio_oe_r,
  // Extended port and status
  input wire ext_wr_r,
  input wire ext_rd_r,
  input wire [DW-1:0] ext_addr_r,
  input wire [DW-1:0] mmd_access_control_r,
  input wire [2:0] phy_addr_r
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Field decode of the access control register
  wire [1:0] fn = mmd_access_control_r[15:14];
  wire [4:0] sp = mmd_access_control_r[4:0];
  wire ok = fn == `PMS_FN_DATA && ext_addr_r >= `PMS_STD_REGS
    && (sp == `PMS_DEV_VEND || sp == `PMS_DEV_EEE_A || sp == `PMS_DEV_EEE_B);
  property p_strap_held;
    $past(rst_b) |-> $stable(phy_addr_r);
  endproperty
  a_strap_held: assert property (p_strap_held) else $error("address moved");
  property p_wr_pulse;
    ext_wr_r |=> !ext_wr_r && !ext_rd_r;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse long");
  property p_rd_pulse;
    ext_rd_r |=> !ext_rd_r;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse long");
  property p_ext_wr_ok;
    ext_wr_r |-> ok;
  endproperty
  a_ext_wr_ok: assert property (p_ext_wr_ok) else $error("bad ext write");
  property p_ext_rd_ok;
    ext_rd_r |-> ok;
  endproperty
  a_ext_rd_ok: assert property (p_ext_rd_ok) else $error("bad ext read");
  property p_addr_fixed;
    !$stable(ext_addr_r) |-> $past(fn) == `PMS_FN_ADDR;
  endproperty
  a_addr_fixed: assert property (p_addr_fixed) else $error("address stepped");
  property p_ta_zero;
    $rose(mdio_oe_r) |-> !mdc && !mdio_out_r ##1 mdio_oe_r [*8];
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround drive");
  property p_hold_rise;
    mdio_oe_r && $changed(mdio_out_r) |-> !mdc;
  endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("data moved high");
  property p_release;
    $fell(mdio_oe_r) |-> mdc;
  endproperty
  a_release: assert property (p_release) else $error("late release");
  c_wr: cover property (ext_wr_r);
  c_rd: cover property (ext_rd_r);
  c_rel: cover property ($fell(mdio_oe_r));
endmodule
bind pms_mdio_slave pms_mdio_props #(.DW(DW)) u_props (.clk(clk), .rst_b(rst_b), .mdc(mdc),
  .mdio_out_r(mdio_out_r), .mdio_oe_r(mdio_oe_r), .ext_wr_r(ext_wr_r), .ext_rd_r(ext_rd_r),
  .ext_addr_r(ext_addr_r), .mmd_access_control_r(mmd_access_control_r),
  .phy_addr_r(phy_addr_r));

/* dv/pms_sta_model.sv */
// Purpose: Station model driving the management clock and data
// Assumes: Line has a pull-up outside
// Notes: Clock stands low between frames
`timescale 1ns/100ps
`include "pms_consts.vh"
module pms_sta_model (
  // System
  input wire clk,
  // Management link
  output reg mdc,
  output reg sta_oe,
  output reg sta_out,
  input wire mdio
);
  reg [1:0] ta_seen;
  integer half;
  initial
  begin
    mdc = 1'b0;
    sta_oe = 1'b0;
    sta_out = 1'b1;
    ta_seen = 2'b00;
    half = 8;
  end
  // One frame; data moves with the fall so it is settled at the rise
  task xfer(input [1:0] op, input [4:0] dv, input [4:0] rg, input [15:0] wd,
    output [15:0] rd);
    reg [31:0] f;
    integer k;
  begin
    f = {2'b01, op, dv, rg, 2'b10, wd};
    for (k = 31; k >= 0; k = k - 1)
    begin
      sta_oe <= op == `PMS_OP_WR || k > 17;
      sta_out <= f[k];
      repeat (half) @(posedge clk);
      mdc <= 1'b1;
      if (k < 16)
        rd = {rd[14:0], mdio};
      if (k == 17 || k == 16)
        ta_seen = {ta_seen[0], mdio};
      repeat (half) @(posedge clk);
      mdc <= 1'b0;
    end
    sta_oe <= 1'b0;
    repeat (16) @(posedge clk);
  end
  endtask
endmodule

/* dv/testbench.sv */
// Purpose: Self-checking bench for the serial management slave
// Assumes: Station model owns mdc and its share of mdio
// Notes: Extended space answers address xor a fixed pattern
`timescale 1ns/100ps
`include "pms_consts.vh"
module testbench;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [2:0] strap = 3'h5;
  reg [15:0] ext_rdata = 16'h0000;
  wire mdc, sta_oe, sta_out, oe, dout, ext_wr, ext_rd;
  wire [15:0] ext_addr, ext_wdata, ctrl;
  wire [2:0] paddr;
  reg [15:0] wr_a, wr_d, rd;
  integer n_errors = 0;
  integer check_count = 0;
  integer cycles = 0;
  integer n_wr = 0;
  integer n_rd = 0;
  integer i;
  localparam [4:0] ME = 5'h05;
  // Pull-up wins when nobody drives
  wire mdio = oe ? dout : (sta_oe ? sta_out : 1'b1);
  always #5 clk = ~clk;
  pms_mdio_slave dut (.clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio), .mdio_out_r(dout),
    .mdio_oe_r(oe), .phy_addr_strap(strap), .ext_wr_r(ext_wr), .ext_rd_r(ext_rd),
    .ext_addr_r(ext_addr), .ext_wdata_r(ext_wdata), .ext_rdata(ext_rdata),
    .mmd_access_control_r(ctrl), .phy_addr_r(paddr));
  pms_sta_model sta (.clk(clk), .mdc(mdc), .sta_oe(sta_oe), .sta_out(sta_out), .mdio(mdio));
  // User side of the extended space, plus hang guard
  always @(posedge clk)
  begin
    ext_rdata <= ext_addr ^ 16'hbeef;
    cycles <= cycles + 1;
    if (ext_wr === 1'b1)
    begin
      n_wr <= n_wr + 1;
      wr_a <= ext_addr;
      wr_d <= ext_wdata;
    end
    if (ext_rd === 1'b1)
      n_rd <= n_rd + 1;
    if (cycles == 60000)
    begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task wr(input [4:0] rg, input [15:0] d);
  begin
    sta.xfer(`PMS_OP_WR, ME, rg, d, rd);
  end
  endtask
  task rdc(input [4:0] rg, input [15:0] e);
  begin
    sta.xfer(`PMS_OP_RD, ME, rg, 16'h0000, rd);
    chk(rd, e);
  end
  endtask
  task t_direct;
  begin
    wr(5'h00, 16'ha5c3);
    wr(5'h1f, 16'h3c5a);
    rdc(5'h00, 16'ha5c3);
    rdc(5'h1f, 16'h3c5a);
    chk({14'h0, sta.ta_seen}, 16'h0002);
    chk({13'h0, paddr}, {13'h0, strap});
    sta.xfer(`PMS_OP_WR, 5'h06, 5'h00, 16'h0000, rd);
    sta.xfer(`PMS_OP_RD, 5'h15, 5'h00, 16'h0000, rd);
    chk(rd, 16'hffff);
    rdc(5'h00, 16'ha5c3);
    $display("test direct done");
  end
  endtask
  // Address function, then data in all three spaces, then refusals
  task t_ext;
  begin
    wr(`PMS_REG_CTRL, 16'h001f);
    chk(ctrl, 16'h001f);
    wr(`PMS_REG_ADDAT, 16'h0461);
    rdc(`PMS_REG_ADDAT, 16'h0461);
    rdc(`PMS_REG_ADDAT, 16'h0461);
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(`PMS_REG_CTRL, {11'h200, i == 0 ? `PMS_DEV_VEND :
        i == 1 ? `PMS_DEV_EEE_A : `PMS_DEV_EEE_B});
      wr(`PMS_REG_ADDAT, 16'h0400 + i[15:0]);
      chk(n_wr[15:0], i[15:0] + 16'h0001);
      chk(wr_a, 16'h0461);
      chk(wr_d, 16'h0400 + i[15:0]);
      rdc(`PMS_REG_ADDAT, 16'h0461 ^ 16'hbeef);
      chk(n_rd[15:0], i[15:0] + 16'h0001);
    end
    wr(`PMS_REG_CTRL, 16'h4001);
    wr(`PMS_REG_ADDAT, 16'h1234);
    chk(n_wr[15:0], 16'h0003);
    rdc(`PMS_REG_ADDAT, 16'hffff);
    wr(`PMS_REG_CTRL, 16'h801f);
    rdc(`PMS_REG_ADDAT, 16'hffff);
    chk(n_rd[15:0], 16'h0003);
    chk(ext_addr, 16'h0461);
    $display("test ext done");
  end
  endtask
  // Indirect path to plain and protected registers
  task t_indirect;
  begin
    wr(`PMS_REG_CTRL, 16'h001f);
    wr(`PMS_REG_ADDAT, 16'h0000);
    wr(`PMS_REG_CTRL, 16'h401f);
    rdc(`PMS_REG_ADDAT, 16'ha5c3);
    wr(`PMS_REG_ADDAT, 16'h7777);
    rdc(5'h00, 16'h7777);
    wr(`PMS_REG_CTRL, 16'h001f);
    wr(`PMS_REG_ADDAT, 16'h000d);
    wr(`PMS_REG_CTRL, 16'h401f);
    wr(`PMS_REG_ADDAT, 16'h0000);
    rdc(`PMS_REG_CTRL, 16'h401f);
    rdc(`PMS_REG_ADDAT, 16'hffff);
    $display("test indirect done");
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (32) @(posedge clk);
    t_direct;
    t_ext;
    t_indirect;
    report_and_stop;
  end
endmodule

/* inc/pms_consts.vh */
// Purpose: Constants for the serial management slave and its extended access
// Assumes: Included by bare name from rtl files
// Notes: Definitions only
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH

// Direct register offsets with special meaning
`define PMS_REG_CTRL 5'h0d
`define PMS_REG_ADDAT 5'h0e

// Access control field layout
`define PMS_FN_HI 15
`define PMS_FN_LO 14
`define PMS_DEV_HI 4
`define PMS_DEV_LO 0

// Access functions
`define PMS_FN_ADDR 2'b00
`define PMS_FN_DATA 2'b01

// Accepted extended space codes
`define PMS_DEV_VEND 5'h1f
`define PMS_DEV_EEE_A 5'h03
`define PMS_DEV_EEE_B 5'h07

// Frame opcodes
`define PMS_OP_RD 2'b10
`define PMS_OP_WR 2'b01

// Reset values
`define PMS_CTRL_RST 16'h0000
`define PMS_ADDR_RST 16'h0000

// Last bit counter values of frame fields
`define PMS_HDR_LAST 5'd11
`define PMS_DATA_LAST 5'd15
`define PMS_SKIP_LAST 5'd17

// Number of directly addressed registers
`define PMS_STD_REGS 16'h0020

`endif

/* rtl/pms_mdio_slave.v */
// Purpose: Serial management slave with direct and indirect extended access
// Assumes: Management clock well below a quarter of clk, sampled as a level
// Notes: Extended register contents live outside, on the ext_* user port
`timescale 1ns/100ps
`include "pms_consts.vh"

// Summary of operation
// - Data line bits are sampled on the rising management clock edge.
// - Three-bit bus address is captured from strap pins during reset.
// - Direct frame register field selects one of 32 16-bit registers.
// - Frame starts from idle high with start pattern 01.
// - Opcode 10 read, 01 write, then addresses, turnaround, 16 data bits.
// - Read turnaround: first bit undriven, device drives 0, then data.
// - Control and address/data registers reachable only by direct frames.
// - Standard registers 0-31 reachable directly; all but 13 and 14 also through indirect access.
// - Only space codes 11111, 00011, 00111 accepted; others ignored.
// - Control bits 15:14 select address (00) or data, no increment (01).
// - Function 00: address/data accesses reach the extended address register.
// - Function 01: accesses reach the addressed extended register, no increment.
module pms_mdio_slave #(
  parameter DW = 16,
  parameter AW = 5
) (
  // System
  input wire clk,
  input wire rst_b,
  // Management pins
  input wire mdc,
  input wire mdio_in,
  output reg mdio_out_r,
  output reg mdio_oe_r,
  // Address straps
  input wire [2:0] phy_addr_strap,
  // Extended register user port
  output reg ext_wr_r,
  output reg ext_rd_r,
  output reg [DW-1:0] ext_addr_r,
  output reg [DW-1:0] ext_wdata_r,
  input wire [DW-1:0] ext_rdata,
  // Status
  output reg [DW-1:0] mmd_access_control_r,
  output reg [2:0] phy_addr_r
);

  // Frame states
  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_HDR = 3'd2;
  localparam ST_TA = 3'd3;
  localparam ST_DATA = 3'd4;
  localparam ST_SKIP = 3'd5;

  // Read data sources
  localparam RS_MEM = 3'd0;
  localparam RS_CTRL = 3'd1;
  localparam RS_ADDR = 3'd2;
  localparam RS_EXT = 3'd3;
  localparam RS_NONE = 3'd4;

  // Space code accepted for indirect access
  function dev_ok;
    input [4:0] dev;
    begin
      dev_ok = (dev == `PMS_DEV_VEND) || (dev == `PMS_DEV_EEE_A) ||
        (dev == `PMS_DEV_EEE_B);
    end
  endfunction

  // Classify an indirect access: source/target code for the current setup
  function [2:0] ind_kind;
    input [DW-1:0] ctrl;
    input [DW-1:0] addr;
    begin
      if (!dev_ok(ctrl[`PMS_DEV_HI:`PMS_DEV_LO]))
        ind_kind = RS_NONE;
      else if (ctrl[`PMS_FN_HI:`PMS_FN_LO] == `PMS_FN_ADDR)
        ind_kind = RS_ADDR;
      else if (ctrl[`PMS_FN_HI:`PMS_FN_LO] != `PMS_FN_DATA)
        ind_kind = RS_NONE;
      else if (addr >= `PMS_STD_REGS)
        ind_kind = RS_EXT;
      else if (addr[AW-1:0] == `PMS_REG_CTRL || addr[AW-1:0] == `PMS_REG_ADDAT)
        ind_kind = RS_NONE;
      else
        ind_kind = RS_MEM;
    end
  endfunction

  wire mdc_s;
  wire mdio_s;
  wire [2:0] strap_s;
  reg mdc_d_r;
  reg [2:0] state_r;
  reg [4:0] cnt_r;
  reg [11:0] hdr_r;
  reg [DW-1:0] wsh_r;
  reg [DW:0] rsh_r;
  reg is_rd_r;
  reg [AW-1:0] ra_r;
  reg [2:0] rsel_r;
  reg [1:0] ld_r;
  reg drv_r;
  reg [AW-1:0] raddr_r;
  reg mem_we_r;
  reg [AW-1:0] mem_waddr_r;
  reg [DW-1:0] mem_wdata_r;
  wire [DW-1:0] mem_rdata;
  wire rise;
  wire fall;
  wire [11:0] hdr_nxt;
  wire [DW-1:0] wsh_nxt;
  reg [2:0] rsel_nxt;
  reg [DW-1:0] rmux;

  // Pins are asynchronous to clk; no reset here, so straps settle while rst_b is low
  pms_sync #(.W(5)) u_sync (
    .clk(clk),
    .rst_b(1'b1),
    .d({mdc, mdio_in, phy_addr_strap}),
    .q({mdc_s, mdio_s, strap_s})
  );

  pms_regmem #(.AW(AW), .DW(DW)) u_mem (
    .clk(clk),
    .we(mem_we_r),
    .waddr(mem_waddr_r),
    .wdata(mem_wdata_r),
    .raddr(raddr_r),
    .rdata(mem_rdata)
  );

  // Edge finding on the synchronised management clock
  assign rise = mdc_s & ~mdc_d_r;
  assign fall = ~mdc_s & mdc_d_r;
  assign hdr_nxt = {hdr_r[10:0], mdio_s};
  assign wsh_nxt = {wsh_r[DW-2:0], mdio_s};

  // Read source chosen from the register field of the finished header
  always @*
  begin
    rsel_nxt = RS_MEM;
    if (hdr_nxt[4:0] == `PMS_REG_CTRL)
      rsel_nxt = RS_CTRL;
    else if (hdr_nxt[4:0] == `PMS_REG_ADDAT)
      rsel_nxt = ind_kind(mmd_access_control_r, ext_addr_r);
  end

  // Read data multiplexer, taken two cycles after the header decision
  always @*
  begin
    case (rsel_r)
      RS_MEM: rmux = mem_rdata;
      RS_CTRL: rmux = mmd_access_control_r;
      RS_ADDR: rmux = ext_addr_r;
      RS_EXT: rmux = ext_rdata;
      default: rmux = {DW{1'b1}};
    endcase
  end

  // Straps follow the pins while reset is held, then stay frozen
  always @(posedge clk)
  begin
    if (!rst_b)
      phy_addr_r <= strap_s;
  end

  // Frame receiver, register file and line driver
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      mdc_d_r <= 1'b0;
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      hdr_r <= 12'h000;
      wsh_r <= {DW{1'b0}};
      rsh_r <= {(DW+1){1'b0}};
      is_rd_r <= 1'b0;
      ra_r <= {AW{1'b0}};
      rsel_r <= RS_NONE;
      ld_r <= 2'b00;
      drv_r <= 1'b0;
      raddr_r <= {AW{1'b0}};
      mem_we_r <= 1'b0;
      mem_waddr_r <= {AW{1'b0}};
      mem_wdata_r <= {DW{1'b0}};
      mdio_out_r <= 1'b0;
      mdio_oe_r <= 1'b0;
      ext_wr_r <= 1'b0;
      ext_rd_r <= 1'b0;
      ext_addr_r <= `PMS_ADDR_RST;
      ext_wdata_r <= {DW{1'b0}};
      mmd_access_control_r <= `PMS_CTRL_RST;
    end
    else
    begin
      mdc_d_r <= mdc_s;
      mem_we_r <= 1'b0;
      ext_wr_r <= 1'b0;
      ext_rd_r <= 1'b0;
      ld_r <= {ld_r[0], 1'b0};
      // Memory and user read data settle before the first falling edge
      if (ld_r[1])
        rsh_r <= {1'b0, rmux};
      // Drive changes on the falling edge so the station sees stable bits
      if (fall && drv_r)
      begin
        mdio_oe_r <= 1'b1;
        mdio_out_r <= rsh_r[DW];
        rsh_r <= {rsh_r[DW-1:0], 1'b0};
      end
      if (rise)
      begin
        case (state_r)
          ST_IDLE:
          begin
            // A low bit after idle high opens the start pattern
            if (!mdio_s)
              state_r <= ST_START;
          end
          ST_START:
          begin
            cnt_r <= 5'h00;
            if (mdio_s)
              state_r <= ST_HDR;
            else
              state_r <= ST_IDLE;
          end
          ST_HDR:
          begin
            hdr_r <= hdr_nxt;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `PMS_HDR_LAST)
            begin
              cnt_r <= 5'h00;
              ra_r <= hdr_nxt[4:0];
              is_rd_r <= (hdr_nxt[11:10] == `PMS_OP_RD);
              rsel_r <= rsel_nxt;
              if (hdr_nxt[9:5] != {2'b00, phy_addr_r})
                state_r <= ST_SKIP;
              else if (hdr_nxt[11:10] == `PMS_OP_RD)
              begin
                state_r <= ST_TA;
                ld_r[0] <= 1'b1;
                raddr_r <= (hdr_nxt[4:0] == `PMS_REG_ADDAT) ? ext_addr_r[AW-1:0] :
                  hdr_nxt[4:0];
                if (rsel_nxt == RS_EXT)
                  ext_rd_r <= 1'b1;
              end
              else if (hdr_nxt[11:10] == `PMS_OP_WR)
                state_r <= ST_TA;
              else
                state_r <= ST_SKIP;
            end
          end
          ST_TA:
          begin
            cnt_r <= cnt_r + 5'h01;
            // First turnaround bit is left to the pull-up; drive from its end
            if (cnt_r == 5'h00 && is_rd_r && rsel_r != RS_NONE)
              drv_r <= 1'b1;
            if (cnt_r == 5'h01)
            begin
              cnt_r <= 5'h00;
              state_r <= ST_DATA;
            end
          end
          ST_DATA:
          begin
            wsh_r <= wsh_nxt;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `PMS_DATA_LAST)
            begin
              state_r <= ST_IDLE;
              cnt_r <= 5'h00;
              // Release at once so the pull-up restores idle
              drv_r <= 1'b0;
              mdio_oe_r <= 1'b0;
              mdio_out_r <= 1'b0;
              if (!is_rd_r)
              begin
                if (ra_r == `PMS_REG_CTRL)
                  mmd_access_control_r <= wsh_nxt;
                else if (ra_r != `PMS_REG_ADDAT)
                begin
                  mem_we_r <= 1'b1;
                  mem_waddr_r <= ra_r;
                  mem_wdata_r <= wsh_nxt;
                end
                else
                begin
                  case (ind_kind(mmd_access_control_r, ext_addr_r))
                    RS_ADDR: ext_addr_r <= wsh_nxt;
                    RS_MEM:
                    begin
                      mem_we_r <= 1'b1;
                      mem_waddr_r <= ext_addr_r[AW-1:0];
                      mem_wdata_r <= wsh_nxt;
                    end
                    RS_EXT:
                    begin
                      ext_wr_r <= 1'b1;
                      ext_wdata_r <= wsh_nxt;
                    end
                    default: ext_wr_r <= 1'b0;
                  endcase
                end
              end
            end
          end
          ST_SKIP:
          begin
            // Turnaround and data of a foreign frame pass undriven
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `PMS_SKIP_LAST)
            begin
              cnt_r <= 5'h00;
              state_r <= ST_IDLE;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

/* rtl/pms_regmem.v */
// Purpose: Register array for the directly addressed management registers
// Assumes: One write and one read port on the same clock
// Notes: Read data is registered, one cycle after the address
`timescale 1ns/100ps
module pms_regmem #(
  parameter AW = 5,
  parameter DW = 16
) (
  // System
  input wire clk,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // Read port
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Contents are undefined until software writes them
  always @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end

endmodule

/* rtl/pms_sync.v */
// Purpose: Two flip-flop synchroniser for a group of asynchronous levels
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module pms_sync #(
  parameter W = 4
) (
  // System
  input wire clk,
  input wire rst_b,
  // Levels
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta_r;
      reg sync_r;
      // Two stages per bit to settle metastability
      always @(posedge clk)
      begin
        if (!rst_b)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end
        else
        begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate

endmodule
